// file: src/dmcs_regs.svh
// Purpose: register map, field positions and reset values of the dma channel status and addressing block
// Assumes: 32-bit classic wishbone slave, byte addresses, one aligned word per register
// Notes: definitions only
// Operation
// [R1] dest done flag on dest pointer equal length
// [R2] dest half-full flag at half dest length
// [R3] block complete on larger length, or pattern match
// [R4] cell complete every cell length bytes
// [R5] abort irq match aborts, sets abort flag
// [R6] address error flag on invalid address
// [R7] 32-bit source start address, resets zero
// [R8] 32-bit dest start address, resets zero
// [R9] source length zero means 65,536 bytes
// [R10] source length bits 31-16 read zero
// [R11] source done and half-empty flags
// [R12] upper-byte enables gate the channel interrupt; the code holds the enables in byte lane 2, bits 23-16
// [R13] flags stay set until written zero
`ifndef DMCS_REGS_SVH
`define DMCS_REGS_SVH

// byte offsets of the four registers
`define DMCS_OFS_INT 8'h00
`define DMCS_OFS_SSA 8'h10
`define DMCS_OFS_DSA 8'h20
`define DMCS_OFS_SSIZ 8'h30

// field positions inside the interrupt and source length registers
`define DMCS_FLAG_LSB 0
`define DMCS_FLAG_MSB 7
`define DMCS_EN_LSB 16
`define DMCS_EN_MSB 23
`define DMCS_LEN_MSB 15

// reset values
`define DMCS_RST_FLAGS 8'h00
`define DMCS_RST_EN 8'h00
`define DMCS_RST_ADDR 32'h0000_0000
`define DMCS_RST_LEN 16'h0000

`endif

// file: src/dmcs_pkg.sv
// Purpose: shared types of the dma channel status and addressing block
// Assumes: included header gives field layout
// Notes: event struct bit order equals the flag byte of the interrupt register
package dmcs_pkg;

  // one bit per status flag, msb first as in the flag byte
  typedef struct packed {
    logic src_done;      // bit 7
    logic src_half;      // bit 6
    logic dst_done;      // bit 5
    logic dst_half;      // bit 4
    logic blk_done;      // bit 3
    logic cell_done;     // bit 2
    logic xfer_abort;    // bit 1
    logic addr_err;      // bit 0
  } dmcs_evt_s;

  // progress reported by the rest of the channel, same clock
  typedef struct packed {
    logic start;             // pulse: new block begins, counters clear
    logic byte_moved;        // pulse: one byte moved, pointers already advanced
    logic [15:0] src_ptr;    // source byte pointer after the move
    logic [15:0] dst_ptr;    // destination byte pointer after the move
    logic pattern_match;     // pulse: pattern detected
    logic irq_valid;         // pulse: an interrupt number is presented
    logic [7:0] irq_num;     // presented interrupt number
    logic addr_invalid;      // pulse: source or destination address found invalid
  } dmcs_xfer_s;

  // register selected by the bus decode
  typedef enum logic [2:0] {
    DMCS_SEL_NONE,
    DMCS_SEL_INT,
    DMCS_SEL_SSA,
    DMCS_SEL_DSA,
    DMCS_SEL_SSIZ
  } dmcs_sel_e;

endpackage

// file: src/dmcs_event_detect.sv
// Purpose: turns channel progress into one-cycle status events
// Assumes: all inputs come from logic on sys_clk
// Notes: events are registered, one cycle after the causing strobe
`timescale 1ns/100ps
`default_nettype none
module dmcs_event_detect
  import dmcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire dmcs_xfer_s xfer,
  input wire logic [15:0] src_len,
  input wire logic [15:0] dst_len,
  input wire logic [15:0] cell_len,
  input wire logic [7:0] abort_irq_num,
  input wire logic abort_irq_en,
  output dmcs_evt_s evt_q
);

  // a length of zero stands for 65,536 bytes, so widen to 17 bits
  function automatic logic [16:0] eff_len(input logic [15:0] len);
    eff_len = (len == 16'h0000) ? 17'h1_0000 : {1'b0, len};
  endfunction

  logic [16:0] src_eff;     // effective source length
  logic [16:0] dst_eff;     // effective destination length
  logic [16:0] cell_eff;    // effective cell length
  logic [16:0] blk_len;     // larger of source and destination
  logic [16:0] blk_cnt_q;   // bytes moved in this block
  logic [16:0] cell_cnt_q;  // bytes moved in this cell
  logic [16:0] blk_cnt_d;
  logic [16:0] cell_cnt_d;
  dmcs_evt_s evt_d;

  assign src_eff = eff_len(src_len); // see [R9]
  assign dst_eff = eff_len(dst_len);
  assign cell_eff = eff_len(cell_len);
  assign blk_len = (src_eff > dst_eff) ? src_eff : dst_eff;
  assign blk_cnt_d = blk_cnt_q + 17'h0_0001;
  assign cell_cnt_d = cell_cnt_q + 17'h0_0001;

  // event decode; a 16-bit pointer wraps to zero at 65,536 so equal compare covers it
  always_comb begin
    evt_d = '0;
    if (xfer.byte_moved) begin
      evt_d.src_done = (xfer.src_ptr == src_len); // see [R11]
      evt_d.src_half = (xfer.src_ptr == src_eff[16:1]); // see [R11]
      evt_d.dst_done = (xfer.dst_ptr == dst_len); // see [R1]
      evt_d.dst_half = (xfer.dst_ptr == dst_eff[16:1]); // see [R2]
      evt_d.blk_done = (blk_cnt_d == blk_len); // see [R3]
      evt_d.cell_done = (cell_cnt_d == cell_eff); // see [R4]
    end
    if (xfer.pattern_match) begin
      evt_d.blk_done = 1'b1; // see [R3]
    end
    // abort request only counts while the abort match is enabled
    evt_d.xfer_abort = xfer.irq_valid && abort_irq_en && (xfer.irq_num == abort_irq_num); // see [R5]
    evt_d.addr_err = xfer.addr_invalid; // see [R6]
  end

  // block byte counter, cleared on start, pattern match, abort and completion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt_q <= 17'h0_0000;
    end else if (xfer.start || xfer.pattern_match || evt_d.blk_done || evt_d.xfer_abort) begin
      blk_cnt_q <= 17'h0_0000;
    end else if (xfer.byte_moved) begin
      blk_cnt_q <= blk_cnt_d;
    end
  end

  // cell byte counter, wraps after each completed cell
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_cnt_q <= 17'h0_0000;
    end else if (xfer.start || xfer.pattern_match || evt_d.cell_done || evt_d.xfer_abort) begin
      cell_cnt_q <= 17'h0_0000; // see [R4]
    end else if (xfer.byte_moved) begin
      cell_cnt_q <= cell_cnt_d;
    end
  end

  // registered event pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt_d;
    end
  end

endmodule
`default_nettype wire

// file: src/dmcs_top.sv
// Purpose: dma channel status flags, interrupt enables, start addresses and source length
// Assumes: classic wishbone slave on sys_clk, channel progress on the same clock
// Notes: every output comes straight from a flip-flop
`timescale 1ns/100ps
`default_nettype none
`include "dmcs_regs.svh"
module dmcs_top
  import dmcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dmcs_xfer_s xfer_i,
  input wire logic [15:0] dest_length,
  input wire logic [15:0] cell_length,
  input wire logic [7:0] abort_request_number,
  input wire logic abort_irq_en,
  output logic [31:0] source_start_address,
  output logic [31:0] dest_start_address,
  output logic [15:0] source_length,
  output logic transfer_abort,
  output logic irq
);

  // decode a byte address into a register select
  function automatic dmcs_sel_e decode(input logic [7:0] adr);
    unique case (adr)
      `DMCS_OFS_INT: decode = DMCS_SEL_INT;
      `DMCS_OFS_SSA: decode = DMCS_SEL_SSA;
      `DMCS_OFS_DSA: decode = DMCS_SEL_DSA;
      `DMCS_OFS_SSIZ: decode = DMCS_SEL_SSIZ;
      default: decode = DMCS_SEL_NONE;
    endcase
  endfunction

  // merge written byte lanes into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    lane_merge = m;
  endfunction

  dmcs_sel_e sel; // register addressed by the current request
  logic req; // a fresh request, not yet acknowledged
  logic wr; // fresh write
  logic [7:0] flags_q; // sticky status flags
  logic [7:0] flags_d;
  logic [7:0] en_q; // interrupt enables, same layout as flags
  logic [7:0] en_d;
  logic [31:0] ssa_d;
  logic [31:0] dsa_d;
  logic [31:0] ssiz_d;
  logic [31:0] rdata; // read mux result
  dmcs_evt_s evt; // event pulses from the detector

  assign sel = decode(wb_adr_i);
  // the ack flop itself gaps back-to-back strobes so each request is taken once
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;

  // event detector sees progress and programmed lengths
  dmcs_event_detect u_evt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .xfer(xfer_i),
    .src_len(source_length),
    .dst_len(dest_length),
    .cell_len(cell_length),
    .abort_irq_num(abort_request_number),
    .abort_irq_en(abort_irq_en),
    .evt_q(evt)
  );

  // wishbone ack: one cycle after the strobe, unmapped addresses answer too
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read mux; unimplemented bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (sel)
      DMCS_SEL_INT: begin
        rdata[`DMCS_FLAG_MSB:`DMCS_FLAG_LSB] = flags_q;
        rdata[`DMCS_EN_MSB:`DMCS_EN_LSB] = en_q;
      end
      DMCS_SEL_SSA: rdata = source_start_address;
      DMCS_SEL_DSA: rdata = dest_start_address;
      DMCS_SEL_SSIZ: rdata[`DMCS_LEN_MSB:0] = source_length; // see [R10]
      DMCS_SEL_NONE: rdata = 32'h0000_0000;
    endcase
  end

  // read data register, loaded with the answer to each request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdata;
    end
  end

  // next flag value: software write replaces, hardware event always wins
  always_comb begin
    flags_d = flags_q;
    if (wr && (sel == DMCS_SEL_INT) && wb_sel_i[0]) begin
      flags_d = wb_dat_i[`DMCS_FLAG_MSB:`DMCS_FLAG_LSB]; // see [R13]
    end
    flags_d = flags_d | evt; // see [R1] see [R2] see [R3] see [R4] see [R5] see [R6] see [R11]
  end

  // sticky status flags; only reset or a write of zero clears them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `DMCS_RST_FLAGS;
    end else begin
      flags_q <= flags_d; // see [R13]
    end
  end

  // enable byte lives in lane 2 of the interrupt register
  always_comb begin
    en_d = en_q;
    if (wr && (sel == DMCS_SEL_INT) && wb_sel_i[2]) begin
      en_d = wb_dat_i[`DMCS_EN_MSB:`DMCS_EN_LSB];
    end
  end

  // interrupt enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `DMCS_RST_EN;
    end else begin
      en_q <= en_d;
    end
  end

  // level interrupt, registered from next-state values so it tracks flags without extra lag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_d & en_d); // see [R12]
    end
  end

  // source start address, byte-lane writable; physical address is software's duty
  assign ssa_d = lane_merge(source_start_address, wb_dat_i, wb_sel_i);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_start_address <= `DMCS_RST_ADDR; // see [R7]
    end else if (wr && (sel == DMCS_SEL_SSA)) begin
      source_start_address <= ssa_d; // see [R7]
    end
  end

  // destination start address, byte-lane writable
  assign dsa_d = lane_merge(dest_start_address, wb_dat_i, wb_sel_i);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_start_address <= `DMCS_RST_ADDR; // see [R8]
    end else if (wr && (sel == DMCS_SEL_DSA)) begin
      dest_start_address <= dsa_d; // see [R8]
    end
  end

  // source length, only the low 16 bits are stored; zero means 65,536 downstream
  assign ssiz_d = lane_merge({16'h0000, source_length}, wb_dat_i, wb_sel_i);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_length <= `DMCS_RST_LEN;
    end else if (wr && (sel == DMCS_SEL_SSIZ)) begin
      source_length <= ssiz_d[`DMCS_LEN_MSB:0]; // see [R10] see [R9]
    end
  end

  // abort pulse to the channel, same cycle as the abort flag sets
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_abort <= 1'b0;
    end else begin
      transfer_abort <= evt.xfer_abort; // see [R5]
    end
  end

endmodule
`default_nettype wire

// file: tb/dmcs_chan_model.sv
// Purpose: stand-in for the channel datapath that reports progress to the status block
// Assumes: one clock, strobes one cycle wide, pointers already advanced in the move cycle
// Notes: on-chip lines, never released, so strobes rest at zero and pointers and irq_num keep their last value
`timescale 1ns/100ps
`default_nettype none
module dmcs_chan_model
  import dmcs_pkg::*;
(
  input wire logic sys_clk,
  output var dmcs_xfer_s xfer
);
  initial xfer = '0;
  // one strobe: 0 new block, 1 pattern hit, 2 bad address
  task automatic pulse(input int which);
    @(posedge sys_clk);
    xfer.start <= (which == 0);
    xfer.pattern_match <= (which == 1);
    xfer.addr_invalid <= (which == 2);
    @(posedge sys_clk);
    xfer.start <= 1'b0;
    xfer.pattern_match <= 1'b0;
    xfer.addr_invalid <= 1'b0;
  endtask
  // a block of n bytes, one byte every cycle, the densest order allowed
  task automatic run(input int n);
    pulse(0);
    for (int i = 1; i <= n; i++) begin
      @(posedge sys_clk);
      xfer.byte_moved <= 1'b1;
      xfer.src_ptr <= 16'(i);
      xfer.dst_ptr <= 16'(i);
    end
    @(posedge sys_clk);
    xfer.byte_moved <= 1'b0;
  endtask
  // present one interrupt number for one cycle
  task automatic irq(input logic [7:0] num);
    @(posedge sys_clk);
    xfer.irq_valid <= 1'b1;
    xfer.irq_num <= num;
    @(posedge sys_clk);
    xfer.irq_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/dmcs_top_checker.sv
// Purpose: bus and abort timing checks at the status block ports
// Assumes: one clock domain, reset active low
// Notes: flag contents are judged by the bench, timing and field gaps here
`timescale 1ns/100ps
`default_nettype none
module dmcs_top_checker
  import dmcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire dmcs_xfer_s xfer_i,
  input wire logic [15:0] dest_length,
  input wire logic [15:0] cell_length,
  input wire logic [7:0] abort_request_number,
  input wire logic abort_irq_en,
  input wire logic [31:0] source_start_address,
  input wire logic [31:0] dest_start_address,
  input wire logic [15:0] source_length,
  input wire logic transfer_abort,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // a request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // matching abort number while the match is enabled
  sequence s_hit;
    xfer_i.irq_valid && abort_irq_en && (xfer_i.irq_num == abort_request_number);
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_abort_hit: assert property (s_hit |-> ##2 transfer_abort)
    else $error("abort pulse missing");
  chk_abort_cause: assert property (transfer_abort |-> $past(xfer_i.irq_valid && abort_irq_en, 2))
    else $error("abort pulse without enabled match");
  chk_ssa_write: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h10 && wb_sel_i == 4'hf)
    |-> source_start_address == $past(wb_dat_i)) else $error("source address not written");
  chk_dsa_hold: assert property (!(wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h20))
    |-> $stable(dest_start_address)) else $error("dest address changed unwritten");
  chk_len_write: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h30 && wb_sel_i == 4'hf)
    |-> source_length == $past(wb_dat_i[15:0])) else $error("source length not written");
  chk_len_upper: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h30)
    |-> wb_dat_o[31:16] == 16'h0000) else $error("length upper half not zero");
  chk_int_gaps: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h00)
    |-> wb_dat_o[31:24] == 8'h00 && wb_dat_o[15:8] == 8'h00) else $error("interrupt gaps not zero");
  chk_irq_masked: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[2])
    && $past(wb_dat_i[23:16] == 8'h00) |-> !irq) else $error("irq with all enables off");
endmodule
bind dmcs_top dmcs_top_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .xfer_i(xfer_i), .dest_length(dest_length), .cell_length(cell_length),
  .abort_request_number(abort_request_number), .abort_irq_en(abort_irq_en), .irq(irq),
  .source_start_address(source_start_address), .dest_start_address(dest_start_address),
  .source_length(source_length), .transfer_abort(transfer_abort));
`default_nettype wire

// file: tb/dmcs_top_tb.sv
// Purpose: register and status flag tests of the channel status block
// Assumes: classic wishbone, ack one cycle after the taking edge
// Notes: the zero length run moves 32768 bytes, the longest part of the run
`timescale 1ns/100ps
`default_nettype none
module dmcs_top_tb import dmcs_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, source_start_address, dest_start_address;
  logic wb_ack_o, transfer_abort, irq;
  dmcs_xfer_s xfer_i;
  // channel settings are driven only through set_chan, so each one is exercised with two values
  logic [15:0] dest_length, cell_length, source_length;
  logic [7:0] abort_request_number;
  logic abort_irq_en;
  logic [31:0] n_errors = 0, checks_done = 0, n_abort = 0;
  always #25 sys_clk = ~sys_clk;
  // count abort pulses, one cycle each
  always @(posedge sys_clk) if (transfer_abort === 1'b1) n_abort <= n_abort + 1;
  dmcs_chan_model u_chan (.sys_clk(sys_clk), .xfer(xfer_i));
  dmcs_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .xfer_i(xfer_i), .dest_length(dest_length), .cell_length(cell_length), .abort_irq_en(abort_irq_en),
    .abort_request_number(abort_request_number), .source_start_address(source_start_address),
    .dest_start_address(dest_start_address), .source_length(source_length),
    .transfer_abort(transfer_abort), .irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle: held until ack is seen, data taken at that edge
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb_cycle(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 4'hf, 32'h0000_0000, q);
    check(q, exp);
  endtask
  // levels that the rest of the channel presents to the block, changed just after an edge
  task automatic set_chan(input logic [15:0] dl, input logic [15:0] cl, input logic [7:0] an, input logic ae);
    dest_length <= dl;
    cell_length <= cl;
    abort_request_number <= an;
    abort_irq_en <= ae;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole sequence needs about 33000 cycles
  initial begin
    #(60000 * 50);
    n_errors = n_errors + 1;
    print_verdict();
  end
  initial begin
    set_chan(16'h0008, 16'h0004, 8'h2a, 1'b0);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    wr(8'h10, 32'h8000_1234, 4'hf);
    rd(8'h10, 32'h8000_1234);
    check(source_start_address, 32'h8000_1234);
    wr(8'h20, 32'ha5a5_0f0f, 4'hf);
    wr(8'h20, 32'h1111_2222, 4'h3); // lower two lanes only
    rd(8'h20, 32'ha5a5_2222);
    wr(8'h30, 32'hffff_abcd, 4'hf);
    rd(8'h30, 32'h0000_abcd);
    wr(8'h40, 32'hffff_ffff, 4'hf); // unmapped, ignored
    rd(8'h40, 32'h0000_0000);
    // six byte source, eight byte dest, four byte cells
    wr(8'h30, 32'h0000_0006, 4'hf);
    u_chan.run(8);
    rd(8'h00, 32'h0000_00fc);
    rd(8'h00, 32'h0000_00fc);
    check(irq, 1'b0);
    wr(8'h00, 32'h0004_00fc, 4'h5);
    check(irq, 1'b1);
    wr(8'h00, 32'h0004_0000, 4'h1);
    check(irq, 1'b0);
    // abort match: disabled, wrong number, then a real hit
    u_chan.irq(8'h2a);
    set_chan(16'h0008, 16'h0004, 8'h2a, 1'b1);
    u_chan.irq(8'h2b);
    u_chan.irq(8'h2a);
    repeat (3) @(posedge sys_clk);
    check(n_abort, 32'h0000_0001);
    rd(8'h00, 32'h0004_0002);
    // a new abort number: the old one no longer matches
    set_chan(16'h0008, 16'h0004, 8'h5c, 1'b1);
    u_chan.irq(8'h2a);
    u_chan.irq(8'h5c);
    repeat (3) @(posedge sys_clk);
    check(n_abort, 32'h0000_0002);
    wr(8'h00, 32'h0004_0000, 4'h1);
    u_chan.pulse(2);
    u_chan.pulse(1);
    rd(8'h00, 32'h0004_0009);
    // zero lengths stand for 65536, so half is reached at 32768
    wr(8'h00, 32'h0004_0000, 4'h1);
    set_chan(16'h0000, 16'h0000, 8'h5c, 1'b1);
    wr(8'h30, 32'h0000_0000, 4'hf);
    u_chan.run(32768);
    rd(8'h00, 32'h0004_0050);
    wr(8'h00, 32'h0000_0000, 4'h5);
    rd(8'h00, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
